// *** verilog/sfd_device.sv ***
// Purpose: device end; frames, decodes and qualifies serial flash instructions
// Assumes: link pins are asynchronous and sampled twice before use
// Notes: array, status and protection content stand outside as plain ports
//
// What this block does
// [RULE_01] Falling select starts frame, clears counters
// [RULE_02] First eight bits are the opcode
// [RULE_03] Sample on rising clock, MSB first
// [RULE_04] Command acts only at rising select
// [RULE_05] Reads may end after any bit
// [RULE_06] Writes discarded unless frame ends byte-aligned
// [RULE_07] Busy ignores all but status read
// [RULE_08] Opcode plus address, dummy, data bytes
// [RULE_09] ABh wakes, skips three dummies, sends ID
// [RULE_10] 50h enables volatile status write
// [RULE_11] 75h requests suspend
// [RULE_12] 7Ah requests resume
// [RULE_13] 44h takes address, erases security register
// [RULE_14] 42h takes address and data, programs
// [RULE_15] 48h address, one dummy, outputs data
// [RULE_16] 01h writes status register one
// [RULE_17] Decode array read, program, erase opcodes
// [RULE_18] Decode single-byte control opcodes
// [RULE_19] 50h keeps latch, qualifies next status write
// [RULE_20] Write latch required for program, erase, write
// [RULE_21] Protected target region ignores erase, program
`timescale 1ns/10ps
`default_nettype none
module sfd_device
	import sfd_pkg::*;
#(
	parameter int FIFO_DEPTH = 16,
	parameter logic [7:0] PART_CODE = 8'h5A // Arbitrary identifier value
) (
	input wire logic clock,
	input wire logic rstn,
	sfd_link_if.dev link,
	input wire logic busy,
	input wire logic region_protected,
	input wire logic [7:0] read_byte,
	output logic addr_valid,
	output logic [23:0] addr,
	output logic data_valid,
	input wire logic data_ready,
	output logic [7:0] data_byte,
	output logic cmd_valid,
	output sfd_cmd_t cmd,
	output logic cmd_volatile,
	output logic write_enable_latch,
	output logic powered_down
);
	// ==========================================
	// Pin synchronisers
	logic sck_s1_r, sck_s2_r, sck_d_r;
	logic cs_s1_r, cs_s2_r, cs_d_r;
	logic si_s1_r, si_s2_r;
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sck_s1_r <= 1'b0; sck_s2_r <= 1'b0; sck_d_r <= 1'b0;
			cs_s1_r <= 1'b1; cs_s2_r <= 1'b1; cs_d_r <= 1'b1;
			si_s1_r <= 1'b0; si_s2_r <= 1'b0;
		end else begin
			sck_s1_r <= link.sck; sck_s2_r <= sck_s1_r; sck_d_r <= sck_s2_r;
			cs_s1_r <= link.cs_n; cs_s2_r <= cs_s1_r; cs_d_r <= cs_s2_r;
			si_s1_r <= link.serial_in; si_s2_r <= si_s1_r;
		end
	end
	logic cs_fall, cs_rise, sck_rise, sck_fall, in_frame;
	assign cs_fall = cs_d_r && !cs_s2_r;
	assign cs_rise = !cs_d_r && cs_s2_r;
	assign in_frame = !cs_s2_r;
	assign sck_rise = in_frame && !sck_d_r && sck_s2_r;
	assign sck_fall = in_frame && sck_d_r && !sck_s2_r;
	// ==========================================
	// Shifter and counters
	logic [7:0] sh_r; // Incoming bits
	logic [2:0] bit_r; // Bit within byte
	logic [3:0] byte_r; // Whole bytes done, saturating
	logic [7:0] op_r; // Latched opcode
	logic [23:0] addr_r;
	logic byte_done;
	assign byte_done = sck_rise && (bit_r == BIT_LAST);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sh_r <= '0; bit_r <= '0; byte_r <= '0; op_r <= '0; addr_r <= '0;
		end else if (cs_fall) begin
			bit_r <= '0; byte_r <= '0; // [RULE_01]
		end else if (sck_rise) begin
			sh_r <= {sh_r[6:0], si_s2_r}; // Rising edge, MSB first [RULE_03]
			bit_r <= bit_r + 3'h1;
			if (bit_r == BIT_LAST) begin
				byte_r <= (byte_r == BYTE_CAP) ? byte_r : byte_r + 4'h1;
				if (byte_r == '0) begin
					op_r <= {sh_r[6:0], si_s2_r}; // First byte is the opcode [RULE_02]
				end else if (byte_r <= ADDR_BYTES) begin
					addr_r <= {addr_r[15:0], sh_r[6:0], si_s2_r}; // MSB byte first [RULE_13]
				end
			end
		end
	end
	// ==========================================
	// Command layout: address present, dummy bytes before output
	logic has_addr, is_read;
	logic [3:0] dummies;
	logic [7:0] op_cur; // Opcode, usable in the cycle its last bit lands
	assign op_cur = (byte_r == '0) ? {sh_r[6:0], si_s2_r} : op_r;
	always_comb begin
		has_addr = 1'b0; is_read = 1'b0; dummies = '0; // [RULE_08]
		unique case (op_cur)
			OP_READ: begin has_addr = 1'b1; is_read = 1'b1; end // [RULE_17]
			OP_FAST_READ, OP_SEC_READ: begin has_addr = 1'b1; is_read = 1'b1; dummies = ONE_DUMMY; end // [RULE_15]
			OP_RELEASE_ID: begin is_read = 1'b1; dummies = ID_DUMMY_BYTES; end // [RULE_09]
			OP_READ_SR1: is_read = 1'b1;
			OP_PAGE_PROG, OP_SEC_PROG, OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K, OP_SEC_ERASE: begin
				has_addr = 1'b1; // [RULE_14]
			end
			default: has_addr = 1'b0;
		endcase
	end
	// Address is complete once three bytes follow the opcode
	logic addr_done;
	assign addr_done = byte_done && has_addr && (byte_r == ADDR_BYTES);
	// ==========================================
	// Outgoing data: one byte per frame byte after the dummies
	logic [7:0] out_r;
	logic so_r, so_oe_r;
	logic first_out;
	// Status read still answers while busy [RULE_07]
	assign first_out = byte_done && is_read && (!busy || op_cur == OP_READ_SR1)
		&& (byte_r == (has_addr ? ADDR_BYTES : 4'h0) + dummies);
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			out_r <= '0; so_r <= 1'b0; so_oe_r <= 1'b0;
		end else if (!in_frame) begin
			so_oe_r <= 1'b0; // Stops output at any bit [RULE_05]
		end else if (first_out || (so_oe_r && byte_done)) begin
			out_r <= (op_r == OP_RELEASE_ID) ? PART_CODE : read_byte; // [RULE_09]
			so_oe_r <= 1'b1;
		end else if (so_oe_r && sck_fall) begin
			so_r <= out_r[3'(BIT_LAST - bit_r)]; // MSB first [RULE_03]
		end
	end
	assign link.serial_out = so_r;
	assign link.serial_out_oe = so_oe_r;
	// ==========================================
	// Data bytes of program and status writes go through a FIFO
	logic push_data, fifo_in_ready;
	assign push_data = byte_done && !busy && ((op_r == OP_WRITE_SR1 && byte_r == 4'h1)
		|| ((op_r == OP_PAGE_PROG || op_r == OP_SEC_PROG) && byte_r > ADDR_BYTES)); // [RULE_16]
	sfd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_data_fifo (
		.clock(clock), .rstn(rstn),
		.in_valid(push_data), .in_ready(fifo_in_ready), .in_data({sh_r[6:0], si_s2_r}),
		.out_valid(data_valid), .out_ready(data_ready), .out_data(data_byte)
	);
	// ==========================================
	// Command commit at rising select
	sfd_cmd_t kind;
	always_comb begin
		unique case (op_r)
			OP_WREN: kind = SFD_CMD_WREN; // [RULE_18]
			OP_WRDI: kind = SFD_CMD_WRDI;
			OP_VSR_WREN: kind = SFD_CMD_VSR_WREN; // [RULE_10]
			OP_PAGE_PROG: kind = SFD_CMD_PROG;
			OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K: kind = SFD_CMD_ERASE;
			OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: kind = SFD_CMD_CHIP_ERASE;
			OP_WRITE_SR1: kind = SFD_CMD_WRITE_SR;
			OP_SEC_ERASE: kind = SFD_CMD_SEC_ERASE; // [RULE_13]
			OP_SEC_PROG: kind = SFD_CMD_SEC_PROG;
			OP_GLOBAL_LOCK: kind = SFD_CMD_LOCK;
			OP_GLOBAL_UNLOCK: kind = SFD_CMD_UNLOCK;
			OP_SUSPEND: kind = SFD_CMD_SUSPEND; // [RULE_11]
			OP_RESUME: kind = SFD_CMD_RESUME; // [RULE_12]
			OP_POWER_DOWN: kind = SFD_CMD_POWER_DOWN;
			OP_RESET: kind = SFD_CMD_RESET;
			default: kind = SFD_CMD_NONE;
		endcase
	end
	logic write_enable_latch_r, powered_down_r, vsr_armed_r, reset_armed_r;
	logic needs_wel, aligned, frame_ok, len_ok;
	assign needs_wel = kind inside {SFD_CMD_PROG, SFD_CMD_ERASE, SFD_CMD_CHIP_ERASE, SFD_CMD_WRITE_SR,
		SFD_CMD_SEC_ERASE, SFD_CMD_SEC_PROG};
	assign aligned = (bit_r == '0) && (byte_r != '0); // [RULE_06]
	assign len_ok = has_addr ? (byte_r > ADDR_BYTES
		|| (byte_r == ADDR_BYTES && op_r != OP_PAGE_PROG && op_r != OP_SEC_PROG)) : 1'b1;
	assign frame_ok = aligned && len_ok && !busy && !is_read && (kind != SFD_CMD_NONE || op_r == OP_RESET_EN)
		&& !(needs_wel && !write_enable_latch_r) // [RULE_20]
		&& !(needs_wel && kind != SFD_CMD_WRITE_SR && region_protected) // [RULE_21]
		&& !(powered_down_r && op_r != OP_RELEASE_ID)
		&& !(kind == SFD_CMD_RESET && !reset_armed_r);
	logic cmd_valid_r, cmd_volatile_r, addr_valid_r;
	sfd_cmd_t cmd_r;
	// Commit, latches and status; busy blocks all but status read [RULE_07]
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cmd_valid_r <= 1'b0; cmd_r <= SFD_CMD_NONE; cmd_volatile_r <= 1'b0; addr_valid_r <= 1'b0;
			write_enable_latch_r <= 1'b0; powered_down_r <= 1'b0; vsr_armed_r <= 1'b0; reset_armed_r <= 1'b0;
		end else begin
			cmd_valid_r <= 1'b0;
			addr_valid_r <= addr_done && !busy;
			if (cs_rise && !busy) begin
				if (op_r == OP_RELEASE_ID && byte_r != '0) begin
					powered_down_r <= 1'b0; // [RULE_09]
				end
				if (frame_ok) begin // Only at rising select [RULE_04]
					cmd_valid_r <= (kind != SFD_CMD_NONE);
					cmd_r <= kind;
					cmd_volatile_r <= (kind == SFD_CMD_WRITE_SR) && vsr_armed_r; // [RULE_19]
					if (kind == SFD_CMD_WREN) write_enable_latch_r <= 1'b1;
					if (kind == SFD_CMD_WRDI || needs_wel) write_enable_latch_r <= 1'b0;
					if (kind == SFD_CMD_POWER_DOWN) powered_down_r <= 1'b1;
					reset_armed_r <= (op_r == OP_RESET_EN);
					vsr_armed_r <= (kind == SFD_CMD_VSR_WREN); // Latch untouched [RULE_19]
				end
			end
		end
	end
	assign cmd_valid = cmd_valid_r;
	assign cmd = cmd_r;
	assign cmd_volatile = cmd_volatile_r;
	assign addr_valid = addr_valid_r;
	assign addr = addr_r;
	assign write_enable_latch = write_enable_latch_r;
	assign powered_down = powered_down_r;
endmodule
`default_nettype wire

// *** verilog/sfd_pkg.sv ***
// Purpose: shared constants for the serial flash instruction decoder and its host end
// Assumes: single-bit SPI, mode 0, opcode byte first, MSB first
// Notes: opcodes, field sizes and timing counts for device and host live here; the test files repeat some as literals
package sfd_pkg;
	// ==========================================
	// Opcodes
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_WRDI = 8'h04;
	localparam logic [7:0] OP_VSR_WREN = 8'h50;
	localparam logic [7:0] OP_RELEASE_ID = 8'hAB;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_FAST_READ = 8'h0B;
	localparam logic [7:0] OP_PAGE_PROG = 8'h02;
	localparam logic [7:0] OP_ERASE_4K = 8'h20;
	localparam logic [7:0] OP_ERASE_32K = 8'h52;
	localparam logic [7:0] OP_ERASE_64K = 8'hD8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_READ_SR1 = 8'h05;
	localparam logic [7:0] OP_WRITE_SR1 = 8'h01;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROG = 8'h42;
	localparam logic [7:0] OP_SEC_READ = 8'h48;
	localparam logic [7:0] OP_GLOBAL_LOCK = 8'h7E;
	localparam logic [7:0] OP_GLOBAL_UNLOCK = 8'h98;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7A;
	localparam logic [7:0] OP_POWER_DOWN = 8'hB9;
	localparam logic [7:0] OP_RESET_EN = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	// ==========================================
	// Framing
	localparam int BITS_PER_BYTE = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [3:0] BYTE_CAP = 4'hF; // Byte counter saturates here
	localparam logic [3:0] ADDR_BYTES = 4'h3;
	localparam logic [3:0] ID_DUMMY_BYTES = 4'h3;
	localparam logic [3:0] ONE_DUMMY = 4'h1;
	// ==========================================
	// Timing
	localparam int CLK_NS = 100;
	localparam int SCK_HALF_NS = 400; // Host serial clock half period
	localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
	// ==========================================
	// Command classes handed to the array side
	typedef enum logic [3:0] {
		SFD_CMD_NONE = 4'h0, SFD_CMD_WREN = 4'h1, SFD_CMD_WRDI = 4'h2, SFD_CMD_VSR_WREN = 4'h3,
		SFD_CMD_PROG = 4'h4, SFD_CMD_ERASE = 4'h5, SFD_CMD_CHIP_ERASE = 4'h6, SFD_CMD_WRITE_SR = 4'h7,
		SFD_CMD_SEC_ERASE = 4'h8, SFD_CMD_SEC_PROG = 4'h9, SFD_CMD_LOCK = 4'hA, SFD_CMD_UNLOCK = 4'hB,
		SFD_CMD_SUSPEND = 4'hC, SFD_CMD_RESUME = 4'hD, SFD_CMD_POWER_DOWN = 4'hE, SFD_CMD_RESET = 4'hF
	} sfd_cmd_t;
endpackage

// *** verilog/sfd_link_if.sv ***
// Purpose: single-bit SPI link between host and flash decoder
// Assumes: pins are plain wires, host drives clock, select and data in
// Notes: serial_out is driven by the device at all times; serial_out_oe marks when it carries data
`timescale 1ns/10ps
`default_nettype none
interface sfd_link_if;
	// ==========================================
	// Link wires
	logic sck; // Serial clock from host
	logic cs_n; // Chip select, active low
	logic serial_in; // Host to device data
	logic serial_out; // Device to host data
	logic serial_out_oe; // High while serial_out carries device data
	modport dev (input sck, input cs_n, input serial_in, output serial_out, output serial_out_oe);
	modport host (output sck, output cs_n, output serial_in, input serial_out, input serial_out_oe);
endinterface
`default_nettype wire

// *** verilog/sfd_fifo.sv ***
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: one clock, synchronous flow
// Notes: full and empty are exact; no write when full, no read when empty
`timescale 1ns/10ps
`default_nettype none
module sfd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic clock,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	// ==========================================
	// Storage and pointers
	logic [WIDTH-1:0] mem_r [DEPTH]; // Entries
	logic [AW-1:0] wr_r; // Write index
	logic [AW-1:0] rd_r; // Read index
	logic [AW:0] cnt_r; // Fill level
	logic push;
	logic pop;
	assign in_ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data = mem_r[rd_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	// Storage write
	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wr_r] <= in_data;
		end
	end
	// Pointer and level update
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + AW'(1);
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + AW'(1);
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// *** verilog/sfd_host.sv ***
// Purpose: host end; frames one command per request onto the SPI link
// Assumes: request carries opcode, byte count to send and byte count to read
// Notes: sends tx bytes from tx port, returns read bytes through a FIFO
`timescale 1ns/10ps
`default_nettype none
module sfd_host
	import sfd_pkg::*;
#(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clock,
	input wire logic rstn,
	sfd_link_if.host link,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [7:0] req_opcode,
	input wire logic [3:0] req_tx_bytes,
	input wire logic [3:0] req_rx_bytes,
	input wire logic [7:0] tx_data,
	output logic tx_take,
	output logic rx_valid,
	input wire logic rx_ready,
	output logic [7:0] rx_data
);
	typedef enum logic [1:0] {HS_IDLE = 2'b00, HS_LOW = 2'b01, HS_HIGH = 2'b11, HS_END = 2'b10} sfd_hst_t;
	// ==========================================
	// State
	sfd_hst_t st_r;
	logic [7:0] sh_r; // Outgoing shift byte
	logic [7:0] rx_r; // Incoming byte
	logic [2:0] bit_r;
	logic [3:0] tx_left_r;
	logic [3:0] rx_left_r;
	logic [7:0] div_r; // Half period divider
	logic sck_r, cs_n_r, do_r, take_r, push_r, rx_ph_r; // rx_ph_r: read bytes under way
	logic so_s1_r, so_s2_r; // Data back from device, synchronised
	logic fifo_in_ready;
	assign link.sck = sck_r;
	assign link.cs_n = cs_n_r;
	assign link.serial_in = do_r;
	assign req_ready = (st_r == HS_IDLE) && fifo_in_ready;
	assign tx_take = take_r;
	// Two-stage sampling of device data
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			so_s1_r <= 1'b0;
			so_s2_r <= 1'b0;
		end else begin
			so_s1_r <= link.serial_out;
			so_s2_r <= so_s1_r;
		end
	end
	// Frame sequencer; waits in idle before a frame while the return FIFO is full
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			st_r <= HS_IDLE; sh_r <= '0; rx_r <= '0; bit_r <= '0; tx_left_r <= '0; rx_left_r <= '0;
			div_r <= '0; sck_r <= 1'b0; cs_n_r <= 1'b1; do_r <= 1'b0; take_r <= 1'b0; push_r <= 1'b0; rx_ph_r <= 1'b0;
		end else begin
			take_r <= 1'b0;
			push_r <= 1'b0;
			div_r <= (div_r == 8'(SCK_HALF_CYC - 1)) ? '0 : div_r + 8'h01;
			unique case (st_r)
				HS_IDLE: begin
					if (req_valid && fifo_in_ready) begin
						cs_n_r <= 1'b0; // Falling select opens the frame [RULE_01]
						sh_r <= {req_opcode[6:0], 1'b0};
						do_r <= req_opcode[7]; // MSB first [RULE_03]
						tx_left_r <= req_tx_bytes;
						rx_left_r <= req_rx_bytes;
						bit_r <= '0; div_r <= '0; rx_ph_r <= 1'b0;
						st_r <= HS_LOW;
					end
				end
				HS_LOW: if (div_r == 8'(SCK_HALF_CYC - 1)) begin
					sck_r <= 1'b1; // Device samples on this rise [RULE_03]
					st_r <= HS_HIGH;
				end
				HS_HIGH: if (div_r == 8'(SCK_HALF_CYC - 1)) begin
					sck_r <= 1'b0;
					// Sampled on the fall: the synchronised bit has settled by now
					rx_r <= {rx_r[6:0], so_s2_r};
					bit_r <= bit_r + 3'h1;
					if (bit_r == BIT_LAST) begin
						if (tx_left_r != '0) begin
							do_r <= tx_data[7]; sh_r <= {tx_data[6:0], 1'b0};
							tx_left_r <= tx_left_r - 4'h1; take_r <= 1'b1; st_r <= HS_LOW;
						end else begin
							push_r <= rx_ph_r; // Byte just done was a read byte
							rx_ph_r <= 1'b1;
							do_r <= 1'b0;
							if (rx_ph_r) rx_left_r <= rx_left_r - 4'h1;
							// Frames always close on a byte edge [RULE_06]
							st_r <= (rx_left_r > 4'(rx_ph_r)) ? HS_LOW : HS_END;
						end
					end else begin
						do_r <= sh_r[7]; sh_r <= {sh_r[6:0], 1'b0};
						st_r <= HS_LOW;
					end
				end
				HS_END: if (div_r == 8'(SCK_HALF_CYC - 1)) begin
					cs_n_r <= 1'b1; // Rising select commits the command [RULE_04]
					st_r <= HS_IDLE;
				end
			endcase
		end
	end
	sfd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
		.clock(clock), .rstn(rstn),
		.in_valid(push_r), .in_ready(fifo_in_ready), .in_data(rx_r),
		.out_valid(rx_valid), .out_ready(rx_ready), .out_data(rx_data)
	);
endmodule
`default_nettype wire

// *** test/sfd_link_props.sv ***
// Purpose: wire-level link checks
// Assumes: mode 0 serial clock, sampled on clock
// Notes: counters track frame bits and idle time
`timescale 1ns/10ps
`default_nettype none
module sfd_link_props (
	input wire logic clock,
	input wire logic rstn,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic serial_in,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	// ==========================================
	// Helper counters
	localparam int MIN_GAP = 16; // Four half periods of select high
	logic sck_d_r; // Serial clock one cycle late
	logic [7:0] bit_cnt_r; // Rising serial clocks in this frame
	logic [7:0] hi_cnt_r; // Cycles with select high, saturating
	// Delay for edge finding
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			sck_d_r <= 1'b0;
		end else begin
			sck_d_r <= sck;
		end
	end
	// Bits clocked while selected; cleared while idle
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			bit_cnt_r <= 8'h00;
		end else if (cs_n) begin
			bit_cnt_r <= 8'h00;
		end else if (sck && !sck_d_r) begin
			bit_cnt_r <= bit_cnt_r + 8'h01;
		end
	end
	// Starts saturated so the first frame after reset is not flagged
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			hi_cnt_r <= 8'hFF;
		end else if (!cs_n) begin
			hi_cnt_r <= 8'h00;
		end else if (hi_cnt_r != 8'hFF) begin
			hi_cnt_r <= hi_cnt_r + 8'h01;
		end
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	a_idle_clock_low: assert property (cs_n |-> !sck)
		else $error("serial clock high outside a frame");
	a_select_fall_setup: assert property ($fell(cs_n) |-> !sck ##1 (!sck)[*3])
		else $error("serial clock moved in first half period of frame");
	a_data_held_high: assert property ((!cs_n && $rose(sck)) |=> $stable(serial_in)[*3])
		else $error("serial input changed while clock high");
	a_clock_half_period: assert property ($changed(sck) |=> $stable(sck)[*3])
		else $error("serial clock half period too short");
	a_byte_aligned_end: assert property ($rose(cs_n) |-> bit_cnt_r[2:0] == 3'h0)
		else $error("frame ended off a byte boundary");
	a_opcode_whole: assert property ($rose(cs_n) |-> bit_cnt_r >= 8'h08)
		else $error("frame ended before a whole opcode");
	a_select_gap_min: assert property ($fell(cs_n) |-> hi_cnt_r >= MIN_GAP)
		else $error("select high time between frames too short");
	a_output_released: assert property ($rose(cs_n) |-> ##[0:6] !serial_out_oe)
		else $error("device kept driving after frame end");
	// ==========================================
	// Coverage of main scenarios
	c_long_frame: cover property ($rose(cs_n) && bit_cnt_r >= 8'h20);
	c_device_drives: cover property (serial_out_oe && serial_out);
	c_opcode_only: cover property ($rose(cs_n) && bit_cnt_r == 8'h08);
endmodule
`default_nettype wire

// *** test/serial_flash_instruction_decoder_test.sv ***
// Purpose: both ends joined over the link
// Assumes: small FIFO depth so one frame can fill a buffer
// Notes: random addresses, data and read bytes from a fixed seed
`timescale 1ns/10ps
`default_nettype none
module serial_flash_instruction_decoder_test;
	import sfd_pkg::*;
	// ==========================================
	// Bench signals
	localparam int DEPTH = 8; // Fits one frame of data bytes
	localparam logic [7:0] PART = 8'hC3; // Arbitrary identifier value
	logic clock = 1'b0;
	logic rstn = 1'b0;
	logic req_valid, req_ready, tx_take, rx_valid, rx_ready;
	logic [7:0] req_opcode, tx_data, rx_data, read_byte, data_byte;
	logic [3:0] req_tx_bytes, req_rx_bytes;
	logic busy, region_protected, addr_valid, data_valid, data_ready;
	logic cmd_valid, cmd_volatile, write_enable_latch, powered_down;
	logic [23:0] addr;
	sfd_cmd_t cmd, last_cmd;
	int seed = 32'h2b473ded;
	int bad_count = 0;
	int n_tests = 0;
	int n_cmd = 0;
	int tx_idx = 0;
	logic [7:0] tx_buf [16];
	logic [7:0] wr_op [9] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60, 8'h44, 8'h42, 8'h02, 8'h01};
	int wr_n [9] = '{3, 3, 3, 0, 0, 3, 4, 4, 1};
	sfd_cmd_t wr_cmd [9] = '{SFD_CMD_ERASE, SFD_CMD_ERASE, SFD_CMD_ERASE, SFD_CMD_CHIP_ERASE,
		SFD_CMD_CHIP_ERASE, SFD_CMD_SEC_ERASE, SFD_CMD_SEC_PROG, SFD_CMD_PROG, SFD_CMD_WRITE_SR};
	logic [7:0] ctl_op [4] = '{8'h75, 8'h7A, 8'h7E, 8'h98};
	sfd_cmd_t ctl_cmd [4] = '{SFD_CMD_SUSPEND, SFD_CMD_RESUME, SFD_CMD_LOCK, SFD_CMD_UNLOCK};
	always #50 clock = ~clock;
	// ==========================================
	// Both ends and the wire checker
	sfd_link_if link();
	sfd_host #(.FIFO_DEPTH(DEPTH)) i_sfd_host (.clock(clock), .rstn(rstn), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_opcode(req_opcode), .req_tx_bytes(req_tx_bytes), .req_rx_bytes(req_rx_bytes),
		.tx_data(tx_data), .tx_take(tx_take), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data));
	sfd_device #(.FIFO_DEPTH(DEPTH), .PART_CODE(PART)) i_sfd_device (.clock(clock), .rstn(rstn), .link(link),
		.busy(busy), .region_protected(region_protected), .read_byte(read_byte), .addr_valid(addr_valid),
		.addr(addr), .data_valid(data_valid), .data_ready(data_ready), .data_byte(data_byte),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_volatile(cmd_volatile),
		.write_enable_latch(write_enable_latch), .powered_down(powered_down));
	sfd_link_props i_sfd_link_props (.clock(clock), .rstn(rstn), .sck(link.sck), .cs_n(link.cs_n),
		.serial_in(link.serial_in), .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe));
	// Count accepted commands and feed the next byte once one is taken
	always @(posedge clock) begin
		if (cmd_valid === 1'b1) begin
			n_cmd++;
			last_cmd = cmd;
		end
		if (tx_take === 1'b1) begin
			tx_idx++;
			tx_data <= tx_buf[tx_idx[3:0]];
		end
	end
	// ==========================================
	// Tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic summarize;
		$display("Tests %0d bad %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One frame; exp_on x leaves the outcome unjudged
	task automatic run(input logic [7:0] op, input int ntx, input int nrx, input logic exp_on, input sfd_cmd_t ec);
		int k;
		bit lo = 1'b0;
		for (int i = 0; i < 16; i++) begin
			tx_buf[i] = $random(seed);
		end
		tx_idx = 0;
		n_cmd = 0;
		tx_data <= tx_buf[0];
		req_opcode <= op;
		req_tx_bytes <= ntx[3:0];
		req_rx_bytes <= nrx[3:0];
		req_valid <= 1'b1;
		k = 0;
		// Taken, opened, closed; a hang ends the run
		do begin
			@(posedge clock);
			k++;
			if (req_ready === 1'b1) req_valid <= 1'b0;
			if (link.cs_n === 1'b0) lo = 1'b1;
		end while (!(lo && link.cs_n === 1'b1) && k < 2500);
		if (k >= 2500) begin
			bad_count++;
			$display("CHECK FAILED frame_end expected done seen timeout");
			summarize();
		end
		// Select stays high four half periods between frames
		repeat (16) @(posedge clock);
		if (exp_on !== 1'bx) begin
			check("command count", {31'h0, exp_on}, n_cmd);
			if (exp_on) check("command kind", ec, last_cmd);
		end
		$display("Test done for opcode %h", op);
	endtask
	// Drain device FIFO (dev) or host FIFO
	task automatic drain(input bit dev, input int n, input logic [7:0] exp);
		int k;
		int got;
		got = 0;
		k = 0;
		data_ready <= dev;
		rx_ready <= !dev;
		while (got < n && k < 100) begin
			@(posedge clock);
			k++;
			if (dev && data_valid === 1'b1) begin
				check("data byte", tx_buf[3 + got], data_byte);
				got++;
			end else if (!dev && rx_valid === 1'b1) begin
				check("read byte", exp, rx_data);
				got++;
			end
		end
		data_ready <= 1'b1;
		rx_ready <= 1'b0;
		@(posedge clock);
		check("bytes drained", n, got);
		check("fifo empty", 0, dev ? data_valid : rx_valid);
	endtask
	// ==========================================
	// Main sequence
	initial begin
		req_valid = 1'b0;
		req_opcode = 8'h00;
		req_tx_bytes = 4'h0;
		req_rx_bytes = 4'h0;
		tx_data = 8'h00;
		rx_ready = 1'b0;
		busy = 1'b0;
		region_protected = 1'b0;
		read_byte = 8'h00;
		data_ready = 1'b1;
		repeat (3) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		check("latch after reset", 0, write_enable_latch);
		run(OP_WREN, 0, 0, 1'b1, SFD_CMD_WREN);
		check("latch set", 1, write_enable_latch);
		run(OP_VSR_WREN, 0, 0, 1'b1, SFD_CMD_VSR_WREN);
		check("latch kept", 1, write_enable_latch);
		run(OP_WRDI, 0, 0, 1'b1, SFD_CMD_WRDI);
		check("latch cleared", 0, write_enable_latch);
		for (int i = 0; i < 4; i++) begin
			run(ctl_op[i], 0, 0, 1'b1, ctl_cmd[i]);
		end
		// Each write kind behind its own write enable
		for (int i = 0; i < 9; i++) begin
			run(OP_WREN, 0, 0, 1'b1, SFD_CMD_WREN);
			run(wr_op[i], wr_n[i], 0, 1'b1, wr_cmd[i]);
			if (wr_n[i] >= 3) check("address", {tx_buf[0], tx_buf[1], tx_buf[2]}, addr);
		end
		check("plain status write", 0, cmd_volatile);
		run(OP_WREN, 0, 0, 1'b1, SFD_CMD_WREN);
		run(OP_VSR_WREN, 0, 0, 1'b1, SFD_CMD_VSR_WREN);
		run(OP_WRITE_SR1, 1, 0, 1'b1, SFD_CMD_WRITE_SR);
		check("volatile status write", 1, cmd_volatile);
		// Refusals: no latch, protected region, busy, unknown opcode, reset not armed
		run(OP_WRDI, 0, 0, 1'b1, SFD_CMD_WRDI);
		run(OP_ERASE_4K, 3, 0, 1'b0, SFD_CMD_NONE);
		run(OP_WREN, 0, 0, 1'b1, SFD_CMD_WREN);
		region_protected <= 1'b1;
		run(OP_ERASE_64K, 3, 0, 1'b0, SFD_CMD_NONE);
		region_protected <= 1'b0;
		busy <= 1'b1;
		read_byte <= $random(seed);
		run(OP_WRDI, 0, 0, 1'b0, SFD_CMD_NONE);
		run(OP_READ_SR1, 0, 1, 1'b0, SFD_CMD_NONE);
		drain(1'b0, 1, read_byte);
		busy <= 1'b0;
		run(8'hFF, 0, 0, 1'b0, SFD_CMD_NONE);
		run(OP_RESET, 0, 0, 1'b0, SFD_CMD_NONE);
		run(OP_RESET_EN, 0, 0, 1'bx, SFD_CMD_NONE);
		run(OP_RESET, 0, 0, 1'b1, SFD_CMD_RESET);
		// Power-down, refusal, wake with identifier
		run(OP_POWER_DOWN, 0, 0, 1'b1, SFD_CMD_POWER_DOWN);
		check("powered down", 1, powered_down);
		run(OP_WREN, 0, 0, 1'b0, SFD_CMD_NONE);
		run(OP_RELEASE_ID, 3, 1, 1'bx, SFD_CMD_NONE);
		check("awake", 0, powered_down);
		drain(1'b0, 1, PART);
		// Plain read fills the stalled host buffer, then fast and security reads
		read_byte <= $random(seed);
		run(OP_READ, 3, DEPTH, 1'b0, SFD_CMD_NONE);
		drain(1'b0, DEPTH, read_byte);
		run(OP_FAST_READ, 4, 2, 1'b0, SFD_CMD_NONE);
		drain(1'b0, 2, read_byte);
		run(OP_SEC_READ, 4, 3, 1'b0, SFD_CMD_NONE);
		drain(1'b0, 3, read_byte);
		// Program fills the stalled device buffer
		run(OP_WREN, 0, 0, 1'b1, SFD_CMD_WREN);
		data_ready <= 1'b0;
		run(OP_PAGE_PROG, 3 + DEPTH, 0, 1'b1, SFD_CMD_PROG);
		drain(1'b1, DEPTH, 8'h00);
		summarize();
	end
endmodule
`default_nettype wire
